// ==== flut_lut_entries.sv ====
// Third and fourth entries of the fan duty table, with an AHB-Lite slave.
// Assumes remote_temp is the filtered, unsigned 1/8 degree reading and
// lower_duty is the duty chosen by the lower table entries.
//
// Functional notes
// - Low-res limit: bit 7 ignored, reads zero
// - High-res limit: half-degree steps to 127.5
// - Low-res limit: whole degrees 0 to 127
// - Above entry 3 limit, entry 3 duty
// - Above entry 4 limit, entry 4 duty
// - Compare 9 temperature bits high, 8 low
// - Limits non-negative; sign assumed zero
// - Table offset added to limit first
// - Low-res duty: bits 7:6 ignored, read zero
// - High-res duty: eight-bit concatenated value
// - Extended duty only at high frequency
// - Low-res duty uses lower six bits
`timescale 1ns/1ps

module flut_lut_entries (
    // Clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // Temperature and duty path
    input  wire logic [flut_pkg::TEMP_W-1:0] remote_temp,
    input  wire logic [7:0]                 lower_duty,
    output logic [7:0]                      pwm_duty,
    output logic [flut_pkg::NUM_ENTRIES-1:0] entry_hit
);

    flut_pkg::flut_aphase_s                 aphase_q;
    flut_pkg::flut_limit_s                  limit_q [flut_pkg::NUM_ENTRIES];
    flut_pkg::flut_duty_s                   duty_q  [flut_pkg::NUM_ENTRIES];
    logic [7:0]                             ctrl_q;
    logic [7:0]                             offset_q;
    logic                                   rd_wait_q;
    logic                                   hreadyout_q;
    logic                                   hresp_q;
    logic [31:0]                            hrdata_q;
    logic [7:0]                             pwm_duty_q;
    logic [flut_pkg::NUM_ENTRIES-1:0]       entry_hit_q;

    logic                                   take;
    logic                                   wr_now;
    logic                                   temp_hires;
    logic                                   duty_hires;
    logic                                   freq_high;
    logic                                   tbl_wr_en;
    logic [flut_pkg::NUM_ENTRIES-1:0]       hit;
    logic [7:0]                             duty_val [flut_pkg::NUM_ENTRIES];
    logic [31:0]                            ent_rd   [flut_pkg::NUM_ENTRIES];
    // Unpacked so each entry's process owns its own select bit
    logic                                   ent_sel  [flut_pkg::NUM_ENTRIES];
    logic [31:0]                            rd_mux;
    logic [7:0]                             duty_d;

    // Mode decode from the table control register
    assign temp_hires = ctrl_q[flut_pkg::CTRL_TEMP_HIRES];
    assign duty_hires = ctrl_q[flut_pkg::CTRL_DUTY_HIRES];
    assign freq_high  = ctrl_q[flut_pkg::CTRL_FREQ_HIGH];
    assign tbl_wr_en  = ctrl_q[flut_pkg::CTRL_WR_EN];

    // Transfer accepted; only low-page addresses decode, byte offset bits ignored
    assign take   = hsel & htrans[1] & hready;
    assign wr_now = aphase_q.valid & aphase_q.write;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase_q <= '0;
        end else if (hready) begin
            aphase_q.valid <= take && (haddr[31:10] == 22'h0);
            aphase_q.write <= hwrite;
            aphase_q.idx   <= haddr[9:2];
        end
    end

    // Reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_q   <= 1'b0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            rd_wait_q   <= take & ~hwrite;
            hreadyout_q <= ~(take & ~hwrite);
            hresp_q     <= 1'b0;
        end
    end

    // Read data latched in the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0;
        end else if (rd_wait_q) begin
            hrdata_q <= aphase_q.valid ? rd_mux : 32'h0;
        end
    end

    // Control and offset registers stay writable at all times
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= flut_pkg::CTRL_RST;
            offset_q <= flut_pkg::OFFSET_RST;
        end else if (wr_now) begin
            if (aphase_q.idx == flut_pkg::IDX_CTRL) begin
                ctrl_q <= hwdata[7:0];
            end
            if (aphase_q.idx == flut_pkg::IDX_OFFSET) begin
                offset_q <= hwdata[7:0];
            end
        end
    end

    // Per-entry storage, comparison and readback
    for (genvar i = 0; i < flut_pkg::NUM_ENTRIES; i++) begin : g_ent
        localparam logic [7:0] LIM_IDX = 8'(flut_pkg::IDX_E3_LIMIT
                                            + flut_pkg::IDX_STRIDE * i);
        localparam logic [7:0] DUT_IDX = 8'(flut_pkg::IDX_E3_DUTY
                                            + flut_pkg::IDX_STRIDE * i);
        logic [flut_pkg::CMP_W-1:0] t_cmp;
        logic [flut_pkg::CMP_W-1:0] l_cmp;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                limit_q[i] <= flut_pkg::LIMIT_RST;
                duty_q[i]  <= flut_pkg::DUTY_RST;
            end else if (wr_now && tbl_wr_en) begin
                if (aphase_q.idx == LIM_IDX) begin
                    limit_q[i].whole_degrees <= hwdata[6:0];
                    if (temp_hires) begin
                        limit_q[i].half_degree <= hwdata[7];
                    end
                end
                if (aphase_q.idx == DUT_IDX) begin
                    duty_q[i].base_bits <= hwdata[5:0];
                    if (duty_hires) begin
                        duty_q[i].extended_bits <= hwdata[7:6];
                    end
                end
            end
        end

        // Limit and reading aligned; the zero top bits keep both positive
        always_comb begin
            if (temp_hires) begin
                t_cmp = {1'b0, remote_temp[10:2]};
                l_cmp = {2'b00, limit_q[i].whole_degrees,
                         limit_q[i].half_degree}
                        + {1'b0, offset_q, 1'b0};
            end else begin
                t_cmp = {2'b00, remote_temp[10:3]};
                l_cmp = {3'b000, limit_q[i].whole_degrees}
                        + {2'b00, offset_q};
            end
        end

        assign hit[i] = t_cmp > l_cmp;

        assign duty_val[i] = (duty_hires && freq_high) ? duty_q[i]
                                                       : {2'b00,
                                                      duty_q[i].base_bits};

        // Readback hides bits that the current mode ignores
        always_comb begin
            ent_sel[i] = 1'b1;
            if (aphase_q.idx == LIM_IDX) begin
                ent_rd[i] = {24'h0,
                             temp_hires & limit_q[i].half_degree,
                             limit_q[i].whole_degrees};
            end else if (aphase_q.idx == DUT_IDX) begin
                ent_rd[i] = {24'h0,
                             duty_hires ? duty_q[i].extended_bits : 2'b00,
                             duty_q[i].base_bits};
            end else begin
                ent_sel[i] = 1'b0;
                ent_rd[i]  = 32'h0;
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0;
        if (aphase_q.idx == flut_pkg::IDX_CTRL) begin
            rd_mux = {24'h0, ctrl_q};
        end else if (aphase_q.idx == flut_pkg::IDX_OFFSET) begin
            rd_mux = {24'h0, offset_q};
        end else if (aphase_q.idx == flut_pkg::IDX_STATUS) begin
            rd_mux[flut_pkg::STAT_DUTY_LSB +: 8] = pwm_duty_q;
            rd_mux[flut_pkg::STAT_HIT_LSB +: flut_pkg::NUM_ENTRIES] =
                entry_hit_q;
        end else begin
            for (int k = 0; k < flut_pkg::NUM_ENTRIES; k++) begin
                if (ent_sel[k]) begin
                    rd_mux = ent_rd[k];
                end
            end
        end
    end

    // Higher entry wins, as its limit sits further up the curve
    always_comb begin
        duty_d = lower_duty;
        if (hit[0]) begin
            duty_d = duty_val[0];
        end
        if (hit[1]) begin
            duty_d = duty_val[1];
        end
    end

    // Registered duty output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_duty_q  <= 8'h00;
            entry_hit_q <= '0;
        end else begin
            pwm_duty_q  <= duty_d;
            entry_hit_q <= hit;
        end
    end

    // Outputs straight from flops
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign hrdata    = hrdata_q;
    assign pwm_duty  = pwm_duty_q;
    assign entry_hit = entry_hit_q;

endmodule

// ==== flut_lut_entries_props.sv ====
// Port checker for the fan table entry bank.
// Bound to flut_lut_entries; sees only its ports, one clock domain.
`timescale 1ns/1ps
module flut_lut_entries_props (
    // Clock and reset
    input wire logic                          hclk,
    input wire logic                          hresetn,
    // Bus
    input wire logic                          hsel,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic                          hready,
    input wire logic                          hreadyout,
    input wire logic                          hresp,
    input wire logic [31:0]                   hrdata,
    // Duty path
    input wire logic [flut_pkg::TEMP_W-1:0]   remote_temp,
    input wire logic [7:0]                    lower_duty,
    input wire logic [7:0]                    pwm_duty,
    input wire logic [flut_pkg::NUM_ENTRIES-1:0] entry_hit
);
    // Address phase accepted at this edge
    wire logic take = hsel && htrans[1] && hready;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_read_one_wait: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    a_idle_ready_high: assert property (
        !(take && !hwrite) |=> hreadyout)
        else $error("hreadyout low without read");
    a_rdata_holds: assert property (
        !$stable(hrdata) |-> hreadyout && !$past(hreadyout))
        else $error("hrdata moved outside read end");
    a_rdata_upper_zero: assert property (
        hreadyout && !$past(hreadyout) |-> hrdata[31:16] == 16'h0)
        else $error("read data upper bits set");
    // Reset values differ from the follow path, so skip first edge
    a_duty_follows_lower: assert property (
        $past(hresetn) && entry_hit == 2'b00
            |-> pwm_duty == $past(lower_duty))
        else $error("no hit but duty not lower");
    a_zero_temp_no_hit: assert property (
        remote_temp == 11'h0 |=> entry_hit == 2'b00)
        else $error("zero temperature hit an entry");
endmodule

bind flut_lut_entries flut_lut_entries_props flut_lut_entries_props_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .remote_temp(remote_temp), .lower_duty(lower_duty),
    .pwm_duty(pwm_duty), .entry_hit(entry_hit));

// ==== flut_lut_entries_tb.sv ====
// Self-checking bench for the fan table entry bank.
// Drives the AHB-Lite slave and duty inputs; reads are checked by queue.
`timescale 1ns/1ps
module flut_lut_entries_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [10:0] remote_temp = 11'h0;
    logic [7:0]  lower_duty = 8'h0;
    logic [7:0]  pwm_duty;
    logic [1:0]  entry_hit;
    logic        rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    int          err_total = 0;
    int          n_checks = 0;
    // Model of stored ctrl, offset, limits, duties
    logic [7:0]  m_ctrl = 8'h00;
    logic [7:0]  m_off = 8'h00;
    logic [7:0]  m_lim[2] = '{8'h7f, 8'h7f};
    logic [7:0]  m_duty[2] = '{8'h3f, 8'h3f};
    logic [31:0] s_exp;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    flut_lut_entries flut_lut_entries_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .remote_temp(remote_temp), .lower_duty(lower_duty),
        .pwm_duty(pwm_duty), .entry_hit(entry_hit));

    initial begin
        forever #5 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One transfer; waits on hready in both phases, so wait states are tolerated
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
        if (idx == flut_pkg::IDX_CTRL) m_ctrl = d;
        else if (idx == flut_pkg::IDX_OFFSET) m_off = d;
        else if (m_ctrl[flut_pkg::CTRL_WR_EN] && idx[7:2] == 6'h15) begin
            // Low-res writes leave the ignored bits as stored
            if (idx[0]) m_duty[idx[1]] = m_ctrl[1] ? d
                                       : {m_duty[idx[1]][7:6], d[5:0]};
            else m_lim[idx[1]] = m_ctrl[0] ? d
                                 : {m_lim[idx[1]][7], d[6:0]};
        end
    endtask

    task automatic rd_reg(input logic [7:0] idx);
        logic [7:0] v;
        v = idx[0] ? m_duty[idx[1]] : m_lim[idx[1]];
        if (!idx[0] && !m_ctrl[0]) v[7] = 1'b0;
        if (idx[0] && !m_ctrl[1]) v[7:6] = 2'b00;
        exp_q.push_back({24'h0, v});
        xfer(1'b0, idx, 8'h0);
    endtask

    // Expected status word from the model
    function automatic logic [31:0] stat_exp(input logic [10:0] t,
                                             input logic [7:0] lo);
        logic [9:0] lim;
        logic [9:0] tv;
        logic [1:0] hit;
        logic [7:0] dv[2];
        for (int i = 0; i < 2; i++) begin
            lim = m_ctrl[0] ? {2'b0, m_lim[i][6:0], m_lim[i][7]}
                              + {1'b0, m_off, 1'b0}
                            : {3'b0, m_lim[i][6:0]} + {2'b0, m_off};
            tv = m_ctrl[0] ? {1'b0, t[10:2]} : {2'b0, t[10:3]};
            hit[i] = tv > lim;
            dv[i] = (m_ctrl[1] && m_ctrl[2]) ? m_duty[i]
                                             : {2'b00, m_duty[i][5:0]};
        end
        return {16'h0, hit[1] ? dv[1] : (hit[0] ? dv[0] : lo), 6'h0, hit};
    endfunction

    // Takes the oldest note when a read completes
    always @(posedge hclk) begin
        if (rd_pend && hready === 1'b1) begin
            rd_pend <= 1'b0;
            check(hrdata, exp_q.pop_front());
        end
        if (hsel && htrans[1] && hready && !hwrite) rd_pend <= 1'b1;
    end

    initial begin
        void'($urandom(32'h2f4a));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++) rd_reg(8'h54 + 8'(i));
        wr(8'h54, 8'h10);
        rd_reg(8'h54);
        exp_q.push_back(32'h0);
        xfer(1'b0, 8'h70, 8'h0);
        wr(flut_pkg::IDX_CTRL, 8'h20);
        wr(8'h54, 8'haa);
        wr(8'h55, 8'hc5);
        rd_reg(8'h54);
        rd_reg(8'h55);
        wr(flut_pkg::IDX_CTRL, 8'h23);
        rd_reg(8'h54);
        rd_reg(8'h55);
        // Random modes, limits and temperatures; some writes disabled
        for (int n = 0; n < 60; n++) begin
            wr(flut_pkg::IDX_CTRL, 8'($urandom_range(0, 7))
                                   | ((n % 5 != 0) ? 8'h20 : 8'h00));
            wr(flut_pkg::IDX_OFFSET, 8'($urandom_range(0, 40)));
            wr(8'h54 + 8'($urandom_range(0, 3)), 8'($urandom));
            remote_temp <= (n % 8 == 0) ? 11'h0 : 11'($urandom);
            lower_duty <= 8'($urandom);
            repeat (2) @(posedge hclk);
            s_exp = stat_exp(remote_temp, lower_duty);
            // Output pins settled two edges after the inputs moved
            check({16'h0, pwm_duty, 6'h0, entry_hit}, s_exp);
            exp_q.push_back(s_exp);
            xfer(1'b0, flut_pkg::IDX_STATUS, 8'h0);
        end
        repeat (3) @(posedge hclk);
        print_verdict();
    end

    // Watchdog well past the expected run length
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule

// ==== flut_pkg.sv ====
// Constants, register map and carrier types for the fan table entry bank.
// Assumes a 100 MHz AHB-Lite clock; no other file is needed.
package flut_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_E3_LIMIT = 8'h54;
    localparam logic [7:0] IDX_E3_DUTY  = 8'h55;
    localparam logic [7:0] IDX_E4_LIMIT = 8'h56;
    localparam logic [7:0] IDX_E4_DUTY  = 8'h57;
    localparam logic [7:0] IDX_CTRL     = 8'h4a;
    localparam logic [7:0] IDX_OFFSET   = 8'h4e;
    localparam logic [7:0] IDX_STATUS   = 8'h60;
    localparam logic [7:0] IDX_STRIDE   = 8'h02;

    // Table control field positions
    localparam int CTRL_TEMP_HIRES = 0;
    localparam int CTRL_DUTY_HIRES = 1;
    localparam int CTRL_FREQ_HIGH  = 2;
    localparam int CTRL_WR_EN      = 5;

    // Status field positions
    localparam int STAT_HIT_LSB  = 0;
    localparam int STAT_DUTY_LSB = 8;

    // Values after reset
    localparam logic [7:0] LIMIT_RST  = 8'h7f;
    localparam logic [7:0] DUTY_RST   = 8'h3f;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] OFFSET_RST = 8'h00;

    // Sizes
    localparam int NUM_ENTRIES = 2;
    localparam int TEMP_W      = 11;
    localparam int CMP_W       = 10;

    // One table entry as stored
    typedef struct packed {
        logic       half_degree;
        logic [6:0] whole_degrees;
    } flut_limit_s;

    typedef struct packed {
        logic [1:0] extended_bits;
        logic [5:0] base_bits;
    } flut_duty_s;

    // Captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] idx;
    } flut_aphase_s;

endpackage
